/* pfcpwm_pkg.sv */
// Constants, register map and types of the symmetric 16-bit PWM timer
package pfcpwm_pkg;
    // ------------------------------------------------------------
    // Widths and counter limits
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam int ADDR_W = 5;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_COUNT = 5'h04;
    localparam logic [4:0] OFS_CMP_A = 5'h08;
    localparam logic [4:0] OFS_CMP_B = 5'h0c;
    localparam logic [4:0] OFS_CAPTURE = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_IRQ_EN = 5'h18;
    localparam logic [4:0] OFS_IRQ_CLR = 5'h1c;
    // ------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------
    localparam int CTRL_W = 11;
    localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
    localparam logic [3:0] MODE_PFC_CMP_A = 4'h9;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;
    localparam int ST_OVF = 0;
    localparam int ST_CMP_A = 1;
    localparam int ST_CMP_B = 2;
    localparam int ST_CAPTURE = 3;
    localparam int ST_W = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;
    localparam logic [3:0] RST_ST = 4'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic waveform_pin_direction_b;
        logic waveform_pin_direction_a;
        logic run;
        logic [1:0] compare_output_mode_b;
        logic [1:0] compare_output_mode_a;
        logic [3:0] wave_mode;
    } pfcpwm_ctrl_s;
    localparam pfcpwm_ctrl_s RST_CTRL = '0;
    typedef struct packed {
        logic match;
        logic counting_up;
    } pfcpwm_evt_s;
endpackage : pfcpwm_pkg

/* pfcpwm_chan.sv */
// One waveform output channel of the symmetric PWM timer
`timescale 1ns/10ps
module pfcpwm_chan
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Compare event and settings
    input pfcpwm_evt_s evt_i,
    input wire logic [1:0] compare_output_mode_i,
    input wire logic waveform_pin_direction_i,
    // Pin
    output logic waveform_out_o,
    output logic waveform_oe_o
);
    logic waveform_out;

    // ------------------------------------------------------------
    // Waveform register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waveform_out <= 1'b0;
        end else if (ce_i && evt_i.match) begin
            case (compare_output_mode_i)
                COM_NONINV: waveform_out <= ~evt_i.counting_up;
                COM_INV: waveform_out <= evt_i.counting_up;
                default: waveform_out <= waveform_out;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Value is driven only while the pin direction selects output
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            waveform_out_o <= 1'b0;
            waveform_oe_o <= 1'b0;
        end else if (ce_i) begin
            waveform_out_o <= waveform_pin_direction_i ? waveform_out : 1'b0;
            waveform_oe_o <= waveform_pin_direction_i;
        end
    end
endmodule : pfcpwm_chan

/* pfcpwm_top.sv */
// Phase and frequency correct 16-bit PWM timer with Avalon-MM registers
//
// Overview of operation
// - Overflow flag sets in the tick where compares reload at BOTTOM.
// - Reaching TOP sets compare-A flag or capture flag, per TOP source.
// - A compare value above TOP never produces a match.
// - Compares reload only at BOTTOM, so both slopes stay equal.
// - Output mode 0x2 gives non-inverted PWM, 0x3 inverted PWM.
// - Waveform reaches the pin only while its direction selects output.
// - Up-count match sets or clears output; down-count match does opposite.
// - Output frequency equals tick rate over two times TOP.
// - Capture as TOP frees channel A; compare A as TOP is buffered.
// - Counter maximum is 0xffff.
// - TOP is reached when the counter equals or passes the selected highest value.
`timescale 1ns/10ps
module pfcpwm_top
    import pfcpwm_pkg::*;
(
    // Clock, reset and enables
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic timer_tick_i,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Waveform pins
    output logic waveform_out_a_o,
    output logic waveform_oe_a_o,
    output logic waveform_out_b_o,
    output logic waveform_oe_b_o,
    // Interrupt
    output logic irq_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pfcpwm_ctrl_s ctrl;
    logic [CNT_W-1:0] counter_value;
    logic counting_up;
    logic [CNT_W-1:0] compare_buf_a;
    logic [CNT_W-1:0] compare_buf_b;
    logic [CNT_W-1:0] compare_value_a;
    logic [CNT_W-1:0] compare_value_b;
    logic [CNT_W-1:0] capture_value_reg;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] irq_en;
    logic [ST_W-1:0] next_status;
    logic [ST_W-1:0] evt;
    logic [CNT_W-1:0] top;
    logic pfc_mode;
    logic step;
    logic at_top;
    logic at_bottom;
    logic bus_take;
    logic bus_wr;
    logic wr_ctrl;
    logic wr_count;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic next_irq;
    logic [31:0] next_readdata;
    pfcpwm_evt_s evt_a;
    pfcpwm_evt_s evt_b;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_pfc(input logic [3:0] m);
        return (m == MODE_PFC_CAPTURE) || (m == MODE_PFC_CMP_A);
    endfunction : is_pfc

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic cmp_hit(input logic [15:0] cnt, input logic [15:0] cmp,
                                     input logic [15:0] tp);
        // A value above TOP is never met, even if the counter still sits above a new TOP
        return (cnt == cmp) && (cmp <= tp);
    endfunction : cmp_hit

    function automatic logic reg_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
        return wr && (a == ofs);
    endfunction : reg_hit

    function automatic logic [15:0] count_down(input logic [15:0] cnt);
        // Never wraps below BOTTOM: a TOP of zero makes the counter alternate between zero and one
        return (cnt == CNT_BOTTOM) ? CNT_BOTTOM : cnt - 16'h0001;
    endfunction : count_down

    // ------------------------------------------------------------
    // Counter sequencing
    // ------------------------------------------------------------
    always_comb begin
        pfc_mode = is_pfc(ctrl.wave_mode);
        // Capture as TOP leaves channel A free; compare A as TOP uses its buffered value
        top = (ctrl.wave_mode == MODE_PFC_CMP_A) ? compare_value_a
                                                 : capture_value_reg;
        // Mode, run and tick all gate the step; other modes hold the count
        step = ce_i && timer_tick_i && ctrl.run && pfc_mode;
        // Counter also turns when above TOP, in case TOP was lowered below it
        at_top = counting_up && ((counter_value >= top) ||
                                 (counter_value == CNT_MAX));
        at_bottom = !counting_up && (counter_value == CNT_BOTTOM);
    end

    // An access is taken at the edge where waitrequest is low
    assign bus_take = ce_i && (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign bus_wr = bus_take && avs_write_i;
    assign wr_ctrl = reg_hit(bus_wr, avs_address_i, OFS_CTRL);
    assign wr_count = reg_hit(bus_wr, avs_address_i, OFS_COUNT);
    // Enable and clear hold one bit per flag, so only byte lane 0 counts
    assign wr_irq_en = reg_hit(bus_wr, avs_address_i, OFS_IRQ_EN) && avs_byteenable_i[0];
    assign wr_irq_clr = reg_hit(bus_wr, avs_address_i, OFS_IRQ_CLR) && avs_byteenable_i[0];
    // Taken from the next state so the line rises with the flag, not a cycle later
    assign next_irq = |(next_status & irq_en);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            counter_value <= CNT_BOTTOM;
            counting_up <= 1'b1;
        end else if (wr_count) begin
            counter_value <= merge16(counter_value, avs_writedata_i, avs_byteenable_i);
        end else if (step) begin
            // 2 * TOP ticks per period give f_tick / (2 * TOP)
            if (at_top) begin
                counting_up <= 1'b0;
                counter_value <= count_down(counter_value);
            end else if (at_bottom) begin
                counting_up <= 1'b1;
                counter_value <= counter_value + 16'h0001;
            end else if (counting_up) begin
                counter_value <= counter_value + 16'h0001;
            end else begin
                counter_value <= count_down(counter_value);
            end
        end
    end

    // ------------------------------------------------------------
    // Double-buffered compares
    // ------------------------------------------------------------
    // Active compares change only at BOTTOM, keeping both slopes equal
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_value_a <= RST_CMP;
            compare_value_b <= RST_CMP;
        end else if (step && at_bottom) begin
            compare_value_a <= compare_buf_a;
            compare_value_b <= compare_buf_b;
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    always_comb begin
        evt = '0;
        evt[ST_OVF] = step && at_bottom;
        evt[ST_CMP_A] = step && (at_top ? (ctrl.wave_mode == MODE_PFC_CMP_A)
                                        : cmp_hit(counter_value, compare_value_a, top));
        evt[ST_CMP_B] = step && cmp_hit(counter_value, compare_value_b, top);
        evt[ST_CAPTURE] = step && at_top && (ctrl.wave_mode == MODE_PFC_CAPTURE);
        // Compare A is TOP in mode 9, so channel A never toggles there
        evt_a.match = step && cmp_hit(counter_value, compare_value_a, top) &&
                      (ctrl.wave_mode != MODE_PFC_CMP_A);
        evt_a.counting_up = counting_up;
        evt_b.match = evt[ST_CMP_B];
        evt_b.counting_up = counting_up;
    end

    // ------------------------------------------------------------
    // Output channels
    // ------------------------------------------------------------
    pfcpwm_chan u_chan_a (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .evt_i(evt_a),
        .compare_output_mode_i(ctrl.compare_output_mode_a),
        .waveform_pin_direction_i(ctrl.waveform_pin_direction_a),
        .waveform_out_o(waveform_out_a_o),
        .waveform_oe_o(waveform_oe_a_o)
    );

    pfcpwm_chan u_chan_b (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .evt_i(evt_b),
        .compare_output_mode_i(ctrl.compare_output_mode_b),
        .waveform_pin_direction_i(ctrl.waveform_pin_direction_b),
        .waveform_out_o(waveform_out_b_o),
        .waveform_oe_o(waveform_oe_b_o)
    );

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= RST_CTRL;
        end else if (wr_ctrl) begin
            // Upper control bits are not stored and read back as zero
            ctrl <= pfcpwm_ctrl_s'(CTRL_W'(merge16(16'(ctrl), avs_writedata_i,
                                                   avs_byteenable_i)));
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_buf_a <= RST_CMP;
            compare_buf_b <= RST_CMP;
            capture_value_reg <= RST_CAPTURE;
        end else if (bus_wr) begin
            case (avs_address_i)
                OFS_CMP_A: compare_buf_a <= merge16(compare_buf_a, avs_writedata_i,
                                                    avs_byteenable_i);
                OFS_CMP_B: compare_buf_b <= merge16(compare_buf_b, avs_writedata_i,
                                                    avs_byteenable_i);
                // Capture TOP is not buffered: a change acts at once
                OFS_CAPTURE: capture_value_reg <= merge16(capture_value_reg, avs_writedata_i,
                                                          avs_byteenable_i);
                default: capture_value_reg <= capture_value_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always_comb begin
        next_status = status;
        if (wr_irq_clr) begin
            next_status = status & ~avs_writedata_i[ST_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        next_status = next_status | evt;
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status <= RST_ST;
        end else if (ce_i) begin
            status <= next_status;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_en <= RST_ST;
        end else if (wr_irq_en) begin
            irq_en <= avs_writedata_i[ST_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM answer
    // ------------------------------------------------------------
    // Unmapped and write-only offsets answer zero so software sees no stale data
    always_comb begin
        case (avs_address_i)
            OFS_CTRL: next_readdata = {21'h0, ctrl};
            OFS_COUNT: next_readdata = {16'h0, counter_value};
            OFS_CMP_A: next_readdata = {16'h0, compare_buf_a};
            OFS_CMP_B: next_readdata = {16'h0, compare_buf_b};
            OFS_CAPTURE: next_readdata = {16'h0, capture_value_reg};
            OFS_STATUS: next_readdata = {28'h0, status};
            OFS_IRQ_EN: next_readdata = {28'h0, irq_en};
            default: next_readdata = RD_UNMAPPED;
        endcase
    end

    // One wait cycle per access: data is sampled while waitrequest is high
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= RD_UNMAPPED;
        end else if (ce_i) begin
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= next_readdata;
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end
endmodule : pfcpwm_top

/* pfcpwm_chk.sv */
// Checker of bus handshake and pin rules of the PWM timer
`timescale 1ns/10ps
module pfcpwm_chk
    import pfcpwm_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Pins
    input wire logic waveform_out_a_o,
    input wire logic waveform_oe_a_o,
    input wire logic waveform_out_b_o,
    input wire logic waveform_oe_b_o
);
    logic ctrl_wr;
    logic rd_ans;
    logic any_ans;
    assign ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL;
    assign any_ans = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    assign rd_ans = avs_read_i && !avs_waitrequest_o;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
    endsequence
    sequence s_ans;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    a_wait_one: assert property (s_req |=> s_ans)
        else $error("wait state not one cycle");
    a_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    // Data is latched on every answer, writes included
    a_read_hold: assert property ($changed(avs_readdata_o) |-> any_ans)
        else $error("read data moved outside an answer");
    a_read_upper: assert property (rd_ans |-> avs_readdata_o[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_read_hole: assert property (rd_ans && (avs_address_i[1:0] != 2'h0
        || avs_address_i == OFS_IRQ_CLR) |-> avs_readdata_o == RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_pin_gate_a: assert property (!waveform_oe_a_o |-> !waveform_out_a_o)
        else $error("pin a driven while input");
    a_pin_gate_b: assert property (!waveform_oe_b_o |-> !waveform_out_b_o)
        else $error("pin b driven while input");
    // Enable trails the control write by one edge, seen two samples later
    a_oe_cause: assert property ($changed(waveform_oe_a_o) |-> $past(ctrl_wr, 2))
        else $error("pin a enable moved without control write");
endmodule : pfcpwm_chk
bind pfcpwm_top pfcpwm_chk i_pfcpwm_chk (.*);

/* pfcpwm_load.sv */
// Load model timing the pulses on one waveform pin
`timescale 1ns/10ps
module pfcpwm_load (
    // Clock
    input wire logic mclk_i,
    // Pin
    input wire logic pin_i,
    input wire logic oe_i,
    // Last high time and period in clocks
    output int high_o,
    output int period_o
);
    logic lvl;
    logic lvl_q = 1'b0;
    int cnt = 0;
    // Undriven pin is pulled low at the load
    assign lvl = oe_i & pin_i;
    always @(posedge mclk_i) begin
        lvl_q <= lvl;
        cnt <= (lvl && !lvl_q) ? 1 : cnt + 1;
        if (lvl && !lvl_q) begin
            period_o <= cnt;
        end
        if (!lvl && lvl_q) begin
            high_o <= cnt;
        end
    end
endmodule : pfcpwm_load

/* pfcpwm_top_test.sv */
// Self-checking bench of the symmetric PWM timer
`timescale 1ns/10ps
module pfcpwm_top_test
    import pfcpwm_pkg::*;
;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic timer_tick_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic [31:0] rd;
    logic avs_waitrequest_o;
    logic waveform_out_a_o, waveform_oe_a_o, waveform_out_b_o, waveform_oe_b_o, irq_o;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 86791;
    int tdiv = 1;
    int tcnt = 0;
    int hi_a, per_a, hi_b, per_b;
    always #5 mclk_i = ~mclk_i;
    // Prescaler stand-in: one tick every tdiv clocks
    always @(posedge mclk_i) begin
        tcnt <= (tcnt + 1 >= tdiv) ? 0 : tcnt + 1;
        timer_tick_i <= (tcnt == 0);
    end
    pfcpwm_top i_pfcpwm_top (.*);
    pfcpwm_load i_pfcpwm_load_a (.mclk_i(mclk_i), .pin_i(waveform_out_a_o),
        .oe_i(waveform_oe_a_o), .high_o(hi_a), .period_o(per_a));
    pfcpwm_load i_pfcpwm_load_b (.mclk_i(mclk_i), .pin_i(waveform_out_b_o),
        .oe_i(waveform_oe_b_o), .high_o(hi_b), .period_o(per_b));
    // ----------
    // Tasks
    // ----------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until waitrequest is sampled low; bounded wait
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge mclk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            n++;
            if (n > 20) begin
                miscompares++;
                wrap_up();
            end
            @(posedge mclk_i);
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, '0);
        chk(rd, exp);
    endtask : rdchk
    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        resetn_i <= 1'b1;
    endtask : do_reset
    function automatic int exp_high(int t, int c, int n, bit inv);
        return inv ? 2 * (t - c) * n : 2 * c * n;
    endfunction : exp_high
    // ----------
    // Scenarios
    // ----------
    initial begin
        do_reset();
        rdchk(OFS_CTRL, 32'(RST_CTRL));
        rdchk(OFS_CMP_A, 32'(RST_CMP));
        rdchk(OFS_CAPTURE, 32'(RST_CAPTURE));
        bus(1'b1, OFS_STATUS, 32'hf);
        rdchk(OFS_STATUS, 32'(RST_ST));
        rdchk(5'h02, RD_UNMAPPED);
        rdchk(OFS_IRQ_CLR, RD_UNMAPPED);
        for (int i = 0; i < 8; i++) begin
            int t;
            int c;
            int k;
            bit m9;
            bit inv;
            pfcpwm_ctrl_s ctl;
            m9 = i[0];
            inv = i[1];
            tdiv = i[2] ? 2 : 1;
            t = 4 + ($unsigned($random(seed)) % 32);
            c = (i == 0) ? 1 : (i == 1) ? t - 1 : 1 + ($unsigned($random(seed)) % (t - 1));
            k = 4 * t * tdiv;
            do_reset();
            ctl = RST_CTRL;
            ctl.wave_mode = m9 ? MODE_PFC_CMP_A : MODE_PFC_CAPTURE;
            ctl.compare_output_mode_a = inv ? COM_INV : COM_NONINV;
            ctl.compare_output_mode_b = ctl.compare_output_mode_a;
            ctl.run = 1'b1;
            ctl.waveform_pin_direction_a = !m9;
            ctl.waveform_pin_direction_b = m9;
            // Capture as TOP parks compare B above TOP, so it must never match
            bus(1'b1, OFS_CMP_A, m9 ? t : c);
            bus(1'b1, OFS_CMP_B, m9 ? c : t + 1);
            bus(1'b1, OFS_CAPTURE, t);
            rdchk(OFS_CMP_A, m9 ? t : c);
            rdchk(OFS_CMP_B, m9 ? c : t + 1);
            bus(1'b1, OFS_CTRL, 32'(ctl));
            repeat (3 * k) @(posedge mclk_i);
            bus(1'b1, OFS_IRQ_CLR, 32'hf);
            repeat (k) @(posedge mclk_i);
            rdchk(OFS_STATUS, m9 ? 32'h7 : 32'hb);
            chk(m9 ? per_b : per_a, k / 2);
            chk(m9 ? hi_b : hi_a, exp_high(t, c, tdiv, inv));
            chk(m9 ? {waveform_oe_a_o, waveform_out_a_o}
                   : {waveform_oe_b_o, waveform_out_b_o}, 0);
            bus(1'b1, OFS_IRQ_EN, 32'h1);
            rdchk(OFS_IRQ_EN, 32'h1);
            chk(irq_o, 1'b1);
            bus(1'b1, OFS_IRQ_EN, m9 ? 32'h8 : 32'h4);
            rdchk(OFS_STATUS, m9 ? 32'h7 : 32'hb);
            chk(irq_o, 1'b0);
            bus(1'b1, OFS_IRQ_EN, 32'hf);
            bus(1'b1, OFS_CTRL, 32'h0);
            bus(1'b1, OFS_IRQ_CLR, 32'hf);
            rdchk(OFS_STATUS, 32'h0);
            chk(irq_o, 1'b0);
            bus(1'b1, OFS_COUNT, 32'hffff_ffff);
            rdchk(OFS_COUNT, 32'(CNT_MAX));
        end
        wrap_up();
    end
endmodule : pfcpwm_top_test
